// ---- hw/octal_dac_frame_ctrl.sv ----
// Octal converter frame decoder, channel registers and APB status port
//
// Notes on behaviour
// - strobe fall starts frame, bits shift in
// - frame is sixteen falling serial clock edges
// - strobe rise after sixteen edges executes frame
// - early strobe rise aborts, only the abort count changes
// - clock edges ignored while strobe high
// - extra edges push old bits out serially
// - output is reference times code over taps
// - A-D use reference_abcd, E-H reference_efgh
// - each channel sleeps or wakes independently
// - sleep termination 2.5k, 100k or open
// - own output register drives each channel
// - bits 15:12 command, 11:0 data, 10-bit drops 1:0
// - channel commands load staging, through also output
// - sleep commands put masked channels to sleep
// - broadcast, channel A update, masked update, through
`timescale 1ns/1ps
module octal_dac_frame_ctrl (
    // Clock and reset
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    // APB slave
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [7:0]                        paddr,
    input  wire logic [31:0]                       pwdata,
    output logic [31:0]                            prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    // Serial link
    input  wire logic                              serial_clock,
    input  wire logic                              frame_strobe_n,
    input  wire logic                              serial_in,
    output logic                                   serial_out,
    // Converter side
    output logic [dac_frame_pkg::CHANNELS-1:0][dac_frame_pkg::CODE_BITS-1:0] channel_code,
    output dac_frame_pkg::term_t [dac_frame_pkg::CHANNELS-1:0]             channel_term,
    output logic [dac_frame_pkg::CHANNELS-1:0]     reference_select
);
    import dac_frame_pkg::*;

    // Frame handoff from the receiver
    logic                                   frame_exec;     // Full frame pulse
    logic                                   frame_abort;    // Aborted frame pulse
    logic [FRAME_BITS-1:0]                  frame_data;     // Captured frame

    // Decoded frame fields
    logic [3:0]                             cmd;            // Command nibble
    logic [CODE_BITS-1:0]                   data_code;      // Code after variant mask
    logic [CHANNELS-1:0]                    chan_mask;      // Channel mask bits

    // Control and state
    logic                                   through_mode;   // write_through_mode when set
    logic                                   narrow_variant; // 10-bit variant when set
    logic [CHANNELS-1:0][CODE_BITS-1:0]     staging;        // Staging registers
    logic [15:0]                            exec_count;     // Frames executed
    logic [15:0]                            abort_count;    // Frames aborted

    // APB decode
    logic                                   apb_setup;      // Setup phase of a transfer
    logic                                   apb_access;     // Completing access phase
    logic                                   apb_wr;         // Completing write
    logic                                   addr_hit;       // Address is mapped
    logic [31:0]                            read_value;     // Word for the current address

    // Serial front end
    serial_frame_rx u_rx (
        .pclk           (pclk),
        .presetn        (presetn),
        .serial_clock   (serial_clock),
        .frame_strobe_n (frame_strobe_n),
        .serial_in      (serial_in),
        .serial_out     (serial_out),
        .frame_exec     (frame_exec),
        .frame_abort    (frame_abort),
        .frame_data     (frame_data)
    );

    // True when the address is a channel word
    function automatic logic is_chan_addr(input logic [7:0] addr);
        is_chan_addr = (addr >= ADDR_CHAN0) && (addr <= ADDR_CHAN_LAST)
                       && (addr[1:0] == 2'h0);
    endfunction

    // Channel index of a channel word address
    function automatic logic [2:0] chan_index(input logic [7:0] addr);
        logic [7:0] rel;
        rel        = addr - ADDR_CHAN0;
        chan_index = rel[4:2];
    endfunction

    // True when a channel write command targets this channel
    function automatic logic cmd_targets(input logic [3:0] c, input int unsigned idx);
        cmd_targets = (c <= CMD_CH_LAST) && (c[2:0] == idx[2:0]);
    endfunction

    // Field extraction; the 10-bit variant drops the two low data bits
    assign cmd       = frame_data[CMD_MSB:CMD_LSB];
    assign data_code = narrow_variant ? (frame_data[DATA_MSB:0] & NARROW_MASK)
                                      : frame_data[DATA_MSB:0];
    assign chan_mask = frame_data[MASK_MSB:0];

    // Bus phases
    assign apb_setup  = psel && !penable;
    assign apb_access = psel && penable && pready;
    assign apb_wr     = apb_access && pwrite;
    assign addr_hit   = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS)
                        || is_chan_addr(paddr);

    // Mode and variant control: software sets both, frame commands steer only the mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            through_mode   <= CTRL_RESET[CTRL_THROUGH];
            narrow_variant <= CTRL_RESET[CTRL_NARROW];
        end else begin
            // Software write comes first, a frame in the same cycle wins
            if (apb_wr && paddr == ADDR_CTRL) begin
                through_mode   <= pwdata[CTRL_THROUGH];
                narrow_variant <= pwdata[CTRL_NARROW];
            end
            if (frame_exec && cmd == CMD_HOLD) begin
                through_mode <= 1'b0;
            end else if (frame_exec && cmd == CMD_THROUGH) begin
                through_mode <= 1'b1;
            end
        end
    end

    // Per-channel staging, output and termination registers
    generate
        for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
            logic load_stage;   // Staging takes the frame code
            logic load_out;     // Output takes the frame code
            logic copy_out;     // Output takes the staging value

            // Which action this frame has on this channel
            always_comb begin
                load_stage = 1'b0;
                load_out   = 1'b0;
                copy_out   = 1'b0;
                if (frame_exec) begin
                    case (cmd)
                        CMD_BROADCAST: begin
                            load_stage = 1'b1;
                            load_out   = 1'b1;
                        end
                        CMD_CH_A_UPD: begin
                            load_stage = (ch == 0);
                            load_out   = (ch == 0);
                            copy_out   = (ch != 0);
                        end
                        CMD_UPD_SEL: begin
                            copy_out = chan_mask[ch];
                        end
                        default: begin
                            if (cmd_targets(cmd, ch)) begin
                                load_stage = 1'b1;
                                load_out   = through_mode;
                            end
                        end
                    endcase
                end
            end

            // Staging register holds the last code written to the channel
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    staging[ch] <= CODE_RESET;
                end else if (load_stage) begin
                    staging[ch] <= data_code;
                end
            end

            // Output register alone sets the converter tap
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    channel_code[ch] <= CODE_RESET;
                end else if (load_out) begin
                    channel_code[ch] <= data_code;
                end else if (copy_out) begin
                    channel_code[ch] <= staging[ch];
                end
            end

            // Termination: sleep commands set it, an output update wakes
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    channel_term[ch] <= TERM_ACTIVE;
                end else if (frame_exec && chan_mask[ch] && cmd == CMD_SLEEP_2K5) begin
                    channel_term[ch] <= TERM_2K5;
                end else if (frame_exec && chan_mask[ch] && cmd == CMD_SLEEP_100K) begin
                    channel_term[ch] <= TERM_100K;
                end else if (frame_exec && chan_mask[ch] && cmd == CMD_SLEEP_HIZ) begin
                    channel_term[ch] <= TERM_HIZ;
                end else if (load_out || copy_out) begin
                    channel_term[ch] <= TERM_ACTIVE;
                end
            end
        end
    endgenerate

    // Reference pairing is fixed: A-D on reference_abcd, E-H on reference_efgh
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reference_select <= REFSEL_RESET;
        end else begin
            reference_select <= REFSEL_RESET;
        end
    end

    // Frame counters; aborted frames change nothing but this count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exec_count  <= 16'h0000;
            abort_count <= 16'h0000;
        end else begin
            if (frame_exec) begin
                exec_count <= exec_count + 16'h0001;
            end
            if (frame_abort) begin
                abort_count <= abort_count + 16'h0001;
            end
        end
    end

    // Read word for the addressed register
    always_comb begin
        read_value = 32'h0000_0000;
        if (paddr == ADDR_CTRL) begin
            read_value[CTRL_THROUGH] = through_mode;
            read_value[CTRL_NARROW]  = narrow_variant;
        end else if (paddr == ADDR_STATUS) begin
            read_value = {abort_count, exec_count};
        end else if (is_chan_addr(paddr)) begin
            read_value[11:0]  = channel_code[chan_index(paddr)];
            read_value[23:12] = staging[chan_index(paddr)];
            read_value[25:24] = channel_term[chan_index(paddr)];
            read_value[26]    = reference_select[chan_index(paddr)];
        end
    end

    // APB answer: registered, ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (apb_setup) begin
            pready  <= 1'b1;
            pslverr <= !addr_hit || (pwrite && paddr != ADDR_CTRL);
            prdata  <= pwrite ? 32'h0000_0000 : read_value;
        end else begin
            // Transfer done or idle; hold the bus quiet
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end

endmodule

// ---- hw/dac_frame_pkg.sv ----
// Shared constants and types for the octal converter serial front end
package dac_frame_pkg;

    // Frame layout
    localparam int unsigned FRAME_BITS     = 16;           // Bits in one serial frame
    localparam int unsigned CMD_MSB        = 15;           // Command field top bit
    localparam int unsigned CMD_LSB        = 12;           // Command field bottom bit
    localparam int unsigned DATA_MSB       = 11;           // Data field top bit
    localparam int unsigned MASK_MSB       = 7;            // Channel mask top bit
    localparam int unsigned EDGE_CNT_W     = 5;            // Width of falling-edge counter
    localparam logic [4:0]  EXEC_EDGES     = 5'h10;        // Edges needed before execution
    localparam logic [4:0]  EDGE_CNT_MAX   = 5'h1F;        // Counter saturation value

    // Converter geometry
    localparam int unsigned CHANNELS       = 8;            // Channels A to H
    localparam int unsigned CODE_BITS      = 12;           // Code width, 12-bit variant
    localparam int unsigned TAP_COUNT      = 4096;         // Divider taps, 12-bit variant
    localparam int unsigned TAP_COUNT_10   = 1024;         // Divider taps, 10-bit variant
    localparam logic [11:0] NARROW_MASK    = 12'hFFC;      // Data bits kept by 10-bit variant
    localparam logic [11:0] CODE_RESET     = 12'h000;      // Staging and output reset code
    localparam logic [7:0]  REFSEL_RESET   = 8'hF0;        // 1 = channel uses reference_efgh

    // Frame commands
    localparam logic [3:0]  CMD_CH_LAST    = 4'h7;         // Highest channel write command
    localparam logic [3:0]  CMD_HOLD       = 4'h8;         // Select write_hold_mode
    localparam logic [3:0]  CMD_THROUGH    = 4'h9;         // Select write_through_mode
    localparam logic [3:0]  CMD_UPD_SEL    = 4'hA;         // Copy staging to output, masked
    localparam logic [3:0]  CMD_CH_A_UPD   = 4'hB;         // Load A, copy others
    localparam logic [3:0]  CMD_BROADCAST  = 4'hC;         // Load every channel
    localparam logic [3:0]  CMD_SLEEP_HIZ  = 4'hD;         // Sleep, high impedance
    localparam logic [3:0]  CMD_SLEEP_100K = 4'hE;         // Sleep, 100k to ground
    localparam logic [3:0]  CMD_SLEEP_2K5  = 4'hF;         // Sleep, 2.5k to ground

    // Output termination of a channel
    typedef enum logic [1:0] {
        TERM_ACTIVE,
        TERM_2K5,
        TERM_100K,
        TERM_HIZ
    } term_t;

    // APB register map, byte addresses
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;        // Mode and variant control
    localparam logic [7:0]  ADDR_STATUS    = 8'h04;        // Frame counters
    localparam logic [7:0]  ADDR_CHAN0     = 8'h08;        // Channel A; next at +4
    localparam logic [7:0]  ADDR_CHAN_LAST = 8'h24;        // Channel H
    localparam int unsigned CTRL_THROUGH   = 0;            // Ctrl bit: write_through_mode
    localparam int unsigned CTRL_NARROW    = 1;            // Ctrl bit: 10-bit variant
    localparam logic [1:0]  CTRL_RESET     = 2'h0;         // Hold mode, 12-bit variant

endpackage

// ---- hw/serial_frame_rx.sv ----
// Serial frame receiver: pin sampling, shift register, edge count, chain output
`timescale 1ns/1ps
module serial_frame_rx (
    // Clock and reset
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    // Serial pins
    input  wire logic                              serial_clock,
    input  wire logic                              frame_strobe_n,
    input  wire logic                              serial_in,
    output logic                                   serial_out,
    // Frame to decoder
    output logic                                   frame_exec,
    output logic                                   frame_abort,
    output logic [dac_frame_pkg::FRAME_BITS-1:0]   frame_data
);
    import dac_frame_pkg::*;

    logic [1:0]                 sclk_sync;     // Serial clock synchroniser
    logic [1:0]                 strobe_sync;   // Strobe synchroniser
    logic [1:0]                 din_sync;      // Data synchroniser
    logic                       sclk_last;     // Previous synced clock
    logic                       strobe_last;   // Previous synced strobe
    logic [FRAME_BITS-1:0]      shift;         // Input shift register
    logic [EDGE_CNT_W-1:0]      edge_cnt;      // Falling edges in this frame
    logic                       sclk_fall;     // Serial clock falling edge
    logic                       strobe_fall;   // Frame start
    logic                       strobe_rise;   // Frame end

    // Two-stage synchronisers; first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_sync   <= 2'h0;
            strobe_sync <= 2'h3;
            din_sync    <= 2'h0;
            sclk_last   <= 1'b0;
            strobe_last <= 1'b1;
        end else begin
            sclk_sync   <= {sclk_sync[0], serial_clock};
            strobe_sync <= {strobe_sync[0], frame_strobe_n};
            din_sync    <= {din_sync[0], serial_in};
            sclk_last   <= sclk_sync[1];
            strobe_last <= strobe_sync[1];
        end
    end

    // Edge detection on the synchronised levels
    assign sclk_fall   = sclk_last & ~sclk_sync[1];
    assign strobe_fall = strobe_last & ~strobe_sync[1];
    assign strobe_rise = ~strobe_last & strobe_sync[1];

    // Shift most significant bit first while strobe is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift      <= '0;
            edge_cnt   <= '0;
            serial_out <= 1'b0;
        end else if (strobe_fall) begin
            edge_cnt   <= '0;
            serial_out <= 1'b0;
        end else if (sclk_fall && !strobe_sync[1]) begin
            shift <= {shift[FRAME_BITS-2:0], din_sync[1]};
            if (edge_cnt != EDGE_CNT_MAX) begin
                edge_cnt <= edge_cnt + 5'h01;
            end
            // Bits shifted out past a full frame go to the next device
            serial_out <= (edge_cnt >= EXEC_EDGES) ? shift[FRAME_BITS-1] : 1'b0;
        end
    end

    // Execute a full frame or abort a short one on strobe rise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_exec  <= 1'b0;
            frame_abort <= 1'b0;
            frame_data  <= '0;
        end else begin
            frame_exec  <= strobe_rise && (edge_cnt >= EXEC_EDGES);
            frame_abort <= strobe_rise && (edge_cnt < EXEC_EDGES);
            if (strobe_rise && (edge_cnt >= EXEC_EDGES)) begin
                frame_data <= shift;
            end
        end
    end

endmodule

// ---- test/dac_frame_sva.sv ----
// Port checker for the octal converter frame controller
`timescale 1ns/1ps
module dac_frame_sva (
    // Clock and reset
    input wire logic                                               pclk,
    input wire logic                                               presetn,
    // APB slave side
    input wire logic                                               psel,
    input wire logic                                               penable,
    input wire logic [7:0]                                         paddr,
    input wire logic [31:0]                                        prdata,
    input wire logic                                               pready,
    input wire logic                                               pslverr,
    // Serial link and converter side
    input wire logic                                               frame_strobe_n,
    input wire logic                                               serial_out,
    input wire logic [dac_frame_pkg::CHANNELS-1:0][dac_frame_pkg::CODE_BITS-1:0] channel_code,
    input wire dac_frame_pkg::term_t [dac_frame_pkg::CHANNELS-1:0] channel_term,
    input wire logic [7:0]                                         reference_select
);
    import dac_frame_pkg::*;
    // One clock domain for every check
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_PREADY_FIRST: assert property (psel && !penable |=> pready)
        else $error("pready missing in first access cycle");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    AST_ERR_QUAL: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_UNMAPPED: assert property (pready && paddr > 8'h24 |-> pslverr)
        else $error("unmapped address not refused");
    AST_DATA_IDLE: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer cycle");
    AST_REFSEL: assert property (reference_select == 8'hF0)
        else $error("reference split wrong");
    AST_CODE_IN_FRAME: assert property (!frame_strobe_n |-> $stable(channel_code))
        else $error("code changed inside a frame");
    AST_TERM_IN_FRAME: assert property (!frame_strobe_n |-> $stable(channel_term))
        else $error("termination changed inside a frame");
    AST_CODE_AT_REST: assert property (frame_strobe_n [*8] |=> $stable(channel_code))
        else $error("code changed while idle");
    AST_CHAIN_QUIET: assert property ($fell(frame_strobe_n) |-> ##6 !serial_out [*8])
        else $error("chain output active early in frame");
    // Main scenarios reached
    COV_ERR: cover property (pready && pslverr);
    COV_CODE: cover property ($changed(channel_code));
    COV_TERM: cover property ($changed(channel_term));
endmodule

// ---- test/serial_host.sv ----
// Behavioural serial controller that sends frames and watches the chain output
`timescale 1ns/1ps
module serial_host (
    // Serial link
    output logic      serial_clock,
    output logic      frame_strobe_n,
    output logic      serial_in,
    input  wire logic serial_out
);
    logic [31:0] so_cap;            // Chain bits seen before each falling edge
    // Idle link: clock rests high, strobe high, data low
    initial begin
        serial_clock = 1'b1;
        frame_strobe_n = 1'b1;
        serial_in = 1'b0;
        so_cap = 32'h0;
    end
    // Sends the low n bits of w, top bit first, at an 800 ns clock period
    task automatic send(input logic [31:0] w, input int n);
        int k;
        #37 frame_strobe_n = 1'b0;
        for (k = n - 1; k >= 0; k--) begin
            serial_in = w[k];
            #400 so_cap = {so_cap[30:0], serial_out};
            serial_clock = 1'b0;    // One edge per bit, far below 40 MHz
            #400 serial_clock = 1'b1;
        end
        #400 frame_strobe_n = 1'b1;
        serial_in = 1'b0;
        #1200;
    endtask
    // Clock pulses outside a frame, strobe kept high
    task automatic idle_clocks(input int n);
        repeat (n) begin
            #400 serial_clock = 1'b0;
            #400 serial_clock = 1'b1;
        end
    endtask
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the octal converter frame controller
`timescale 1ns/1ps
module tb_top;
    import dac_frame_pkg::*;
    logic                               pclk, presetn, psel, penable, pwrite, er;
    logic [7:0]                         paddr;
    logic [31:0]                        pwdata, prdata, rd, r0;
    logic                               pready, pslverr, serial_out;
    logic                               serial_clock, frame_strobe_n, serial_in;
    logic [CHANNELS-1:0][CODE_BITS-1:0] channel_code;
    term_t [CHANNELS-1:0]               channel_term;
    logic [7:0]                         reference_select;
    int                                 fails, n_tests, i;
    octal_dac_frame_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_clock(serial_clock), .frame_strobe_n(frame_strobe_n),
        .serial_in(serial_in), .serial_out(serial_out), .channel_code(channel_code),
        .channel_term(channel_term), .reference_select(reference_select));
    serial_host u_host (.serial_clock(serial_clock), .frame_strobe_n(frame_strobe_n),
        .serial_in(serial_in), .serial_out(serial_out));
    // Clock at 100 ns
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // Verdict and end of run
    task wrap_up;
        if (fails == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] x);
        n_tests++;
        if (s !== x) begin
            fails++;
            $display("wrong value at %0t: saw %h expected %h", $time, s, x);
        end
    endtask
    // One APB transfer; only the watchdog bounds the wait for pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // One whole frame, then time for it to execute
    task fr(input logic [15:0] w);
        u_host.send({16'h0, w}, 16);
        repeat (8) @(posedge pclk);
    endtask
    function logic [31:0] cd(input int c);
        return {20'h0, channel_code[c]};
    endfunction
    task s_reset;
        for (i = 0; i < 8; i++) chk(cd(i), 32'h0);
        chk({24'h0, reference_select}, 32'hF0);
        apb(1'b0, ADDR_CTRL, 32'h0); chk(rd, 32'h0);
        apb(1'b0, 8'h80, 32'h0); chk({31'h0, er}, 32'h1);
        apb(1'b1, ADDR_STATUS, 32'h5); chk({31'h0, er}, 32'h1);
    endtask
    task s_modes;
        fr(16'h2ABC); chk(cd(2), 32'h0);
        apb(1'b0, ADDR_CHAN0 + 8'h08, 32'h0); chk({20'h0, rd[23:12]}, 32'hABC);
        fr(16'hA004); chk(cd(2), 32'hABC);
        fr(16'h9000); fr(16'h5123); chk(cd(5), 32'h123);
        fr(16'h8000); fr(16'h5456); chk(cd(5), 32'h123);
        apb(1'b1, ADDR_CTRL, 32'h1); fr(16'h6333); chk(cd(6), 32'h333);
        apb(1'b1, ADDR_CTRL, 32'h0);
    endtask
    task s_sleep;
        for (i = 0; i < 3; i++) begin
            fr({4'hF - i[3:0], 4'h0, 8'h01 << i});
            chk({30'h0, channel_term[i]}, i + 1);
        end
        chk({30'h0, channel_term[7]}, 32'h0); chk(cd(1), 32'h0);
        chk(cd(2), 32'hABC);
    endtask
    task s_special;
        fr(16'hC7FF); fr(16'h3222); fr(16'hB001);
        chk(cd(0), 32'h001); chk(cd(3), 32'h222); chk(cd(7), 32'h7FF);
        chk({30'h0, channel_term[0]}, 32'h0);
    endtask
    task s_abort;
        apb(1'b0, ADDR_STATUS, 32'h0); r0 = rd;
        u_host.send(32'hC555, 15); u_host.send(32'h1F, 5); repeat (8) @(posedge pclk);
        chk(cd(0), 32'h001); chk(cd(4), 32'h7FF);
        apb(1'b0, ADDR_STATUS, 32'h0); chk(rd[31:16], r0[31:16] + 2);
        chk({16'h0, rd[15:0]}, {16'h0, r0[15:0]});
    endtask
    task s_chain;
        u_host.send({16'h1235, 16'hC0F0}, 32); repeat (8) @(posedge pclk);
        chk(cd(0), 32'h0F0); chk(cd(7), 32'h0F0);
        chk(u_host.so_cap, 32'h0000091A);
        // Clock edges with the strobe high must not shift the chain output
        u_host.idle_clocks(4); repeat (8) @(posedge pclk);
        chk({31'h0, serial_out}, 32'h1);
        chk(cd(3), 32'h0F0);
        apb(1'b1, ADDR_CTRL, 32'h2); fr(16'hC123); chk(cd(4), 32'h120);
        chk({31'h0, serial_out}, 32'h0);
    endtask
    // Reset, then the scenarios in order
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h0; pwdata = 32'h0; fails = 0; n_tests = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        s_reset; s_modes; s_sleep; s_special; s_abort; s_chain;
        wrap_up;
    end
    // Watchdog well beyond the expected run
    initial begin
        #3000000;
        fails++;
        wrap_up;
    end
endmodule
bind octal_dac_frame_ctrl dac_frame_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_strobe_n(frame_strobe_n), .serial_out(serial_out), .channel_code(channel_code),
    .channel_term(channel_term), .reference_select(reference_select));
